// [hw/packet_log_capture_select.sv]
/*
  Packet log capture selector: an APB register that picks which internal
  packet streams are copied into the packet log, the capture sequencer
  that appends chosen packets in arrival order, and a readout port.
  Assumes the packet paths and the log reader run on pclk; device reset
  is presetn, and a serial-bus reset never reaches this block.

  // Behaviour
  // - control resets to zero, bus reset ignored
  // - bit 0 logs async transmit packets
  // - bit 1 logs async receive packets
  // - bit 2 logs management agent packets
  // - bit 3 logs management transmit queue packets
  // - bit 4 logs management receive packets
  // - bit 5 logs command agent packets
  // - bit 6 logs command transmit queue packets
  // - bit 7 logs command receive packets
  // - bit 8 logs data-transmit write requests
  // - bit 9 logs data-transmit write responses
  // - bit 10 logs data-receive read requests
  // - bit 11 logs data-receive read responses
  // - bit 15 empties log, then self-clears
  // - read-only bit 19 reports log full
*/
module packet_log_capture_select
  import capture_log_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [31:0]  paddr,
  input  wire logic [31:0]  pwdata,
  input  wire logic [3:0]   pstrb,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire packet_word_s packet_in,
  input  wire logic         log_read,
  output log_word_s         log_out,
  output logic              capture_store_full
);

  // ********************************************************************
  // types and state
  // ********************************************************************
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_TAKE = 3'b010,
    SEQ_SKIP = 3'b100
  } sequence_e;

  typedef struct packed {
    logic         capture_async_tx_fifo;
    logic         capture_async_rx_fifo;
    logic         capture_mgmt_agent;
    logic         capture_mgmt_tx_queue;
    logic         capture_mgmt_rx_fifo;
    logic         capture_command_agent;
    logic         capture_command_tx_queue;
    logic         capture_command_rx_fifo;
    logic         capture_data_tx_write_request;
    logic         capture_data_tx_write_response;
    logic         capture_data_rx_read_request;
    logic         capture_data_rx_read_response;
  } capture_select_s;

  typedef struct packed {
    capture_select_s select;
    logic            capture_store_clear;
    sequence_e       seq;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    log_word_s       log_out;
    logic            capture_store_full;
  } top_state_s;

  top_state_s          state;
  top_state_s          next_state;

  logic [STORE_CW-1:0] store_count;
  logic [31:0]         store_head;
  logic                store_push;
  logic                store_pop;
  logic                setup_phase;
  logic                access_done;
  logic                addr_hit;
  logic                reg_write;
  logic                select_hit;
  logic                store_has_room;

  // ********************************************************************
  // helper functions
  // ********************************************************************
  // packs the source selections in control bit order, bit 0 first
  function automatic source_mask_t select_mask(input capture_select_s s);
    source_mask_t m;
    m                    = '0;
    m[BIT_ASYNC_TX]      = s.capture_async_tx_fifo;
    m[BIT_ASYNC_RX]      = s.capture_async_rx_fifo;
    m[BIT_MGMT_AGENT]    = s.capture_mgmt_agent;
    m[BIT_MGMT_TX_QUEUE] = s.capture_mgmt_tx_queue;
    m[BIT_MGMT_RX_FIFO]  = s.capture_mgmt_rx_fifo;
    m[BIT_CMD_AGENT]     = s.capture_command_agent;
    m[BIT_CMD_TX_QUEUE]  = s.capture_command_tx_queue;
    m[BIT_CMD_RX_FIFO]   = s.capture_command_rx_fifo;
    m[BIT_DATA_TX_WRREQ] = s.capture_data_tx_write_request;
    m[BIT_DATA_TX_WRRSP] = s.capture_data_tx_write_response;
    m[BIT_DATA_RX_RDREQ] = s.capture_data_rx_read_request;
    m[BIT_DATA_RX_RDRSP] = s.capture_data_rx_read_response;
    return m;
  endfunction : select_mask

  // inverse of select_mask, used by the register write path
  function automatic capture_select_s mask_select(input source_mask_t m);
    capture_select_s s;
    s.capture_async_tx_fifo          = m[BIT_ASYNC_TX];
    s.capture_async_rx_fifo          = m[BIT_ASYNC_RX];
    s.capture_mgmt_agent             = m[BIT_MGMT_AGENT];
    s.capture_mgmt_tx_queue          = m[BIT_MGMT_TX_QUEUE];
    s.capture_mgmt_rx_fifo           = m[BIT_MGMT_RX_FIFO];
    s.capture_command_agent          = m[BIT_CMD_AGENT];
    s.capture_command_tx_queue       = m[BIT_CMD_TX_QUEUE];
    s.capture_command_rx_fifo        = m[BIT_CMD_RX_FIFO];
    s.capture_data_tx_write_request  = m[BIT_DATA_TX_WRREQ];
    s.capture_data_tx_write_response = m[BIT_DATA_TX_WRRSP];
    s.capture_data_rx_read_request   = m[BIT_DATA_RX_RDREQ];
    s.capture_data_rx_read_response  = m[BIT_DATA_RX_RDRSP];
    return s;
  endfunction : mask_select

  // merges written bytes over the old word, lanes chosen by pstrb
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_word,
                                              input logic [31:0] new_word,
                                              input logic [3:0]  strb);
    logic [31:0] w;
    w = old_word;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        w[i*8 +: 8] = new_word[i*8 +: 8];
      end
    end
    return w;
  endfunction : merge_bytes

  // true when the store holds its full depth of quadlets
  function automatic logic store_is_full(input logic [STORE_CW-1:0] c);
    return c == STORE_DEPTH_COUNT;
  endfunction : store_is_full

  // a quadlet that closes its packet
  function automatic logic closes_packet(input packet_word_s p);
    return p.valid && p.last;
  endfunction : closes_packet

  // full register image as software sees it
  function automatic logic [31:0] control_image(input top_state_s s,
                                                input logic [STORE_CW-1:0] c);
    logic [31:0]             img;
    logic [STORE_CW-1:0]     space;
    img                                  = '0;
    img[SOURCE_LSB +: SOURCE_COUNT]      = select_mask(s.select);
    img[BIT_STORE_CLEAR]                 = s.capture_store_clear;
    img[BIT_STORE_FULL]                  = store_is_full(c);
    space                                = STORE_DEPTH_COUNT - c;
    img[SPACE_LSB +: SPACE_WIDTH]        = {{(SPACE_WIDTH-STORE_CW){1'b0}},
                                            space};
    return img;
  endfunction : control_image

  // reset image: selects from the register reset value, sequencer idle
  localparam top_state_s STATE_RESET = '{
    select:              mask_select(
                         CAPTURE_CONTROL_RESET[SOURCE_LSB +: SOURCE_COUNT]),
    capture_store_clear: CAPTURE_CONTROL_RESET[BIT_STORE_CLEAR],
    seq:                 SEQ_IDLE,
    prdata:              32'h00000000,
    pready:              1'b0,
    pslverr:             1'b0,
    log_out:             '{valid: 1'b0, word: 32'h00000000},
    capture_store_full:  1'b0
  };

  // ********************************************************************
  // bus decode
  // ********************************************************************
  // one wait-free access: pready is raised for the access phase only
  assign setup_phase    = psel && !penable;
  assign access_done    = psel && penable && state.pready;
  // upper address bits must be zero, so no alias reaches the register
  assign addr_hit       = (paddr[31:8] == 24'h000000) &&
                          (paddr[7:0] == CAPTURE_CONTROL_ADDR);
  assign reg_write      = access_done && pwrite && addr_hit;
  // a packet qualifies if it passed through any selected source
  assign select_hit     = |(packet_in.sources & select_mask(state.select));
  assign store_has_room = !store_is_full(store_count);

  // ********************************************************************
  // capture sequencer and store strobes
  // ********************************************************************
  // words go in as they arrive, so stored packets keep arrival order;
  // once the store fills, the rest of that packet is dropped
  always_comb begin
    store_push = 1'b0;
    case (state.seq)
      SEQ_IDLE: begin
        store_push = packet_in.valid && packet_in.first && select_hit &&
                     store_has_room;
      end
      SEQ_TAKE: begin
        store_push = packet_in.valid && store_has_room;
      end
      SEQ_SKIP: begin
        store_push = 1'b0;
      end
      default: begin
        store_push = 1'b0;
      end
    endcase
    if (state.capture_store_clear) begin
      store_push = 1'b0;
    end
  end

  // a read is honoured only when a word is waiting
  // and never in the clear cycle, whose head word is being discarded
  assign store_pop = log_read && (store_count != '0) &&
                     !state.capture_store_clear;

  // ********************************************************************
  // next state
  // ********************************************************************
  always_comb begin
    next_state = state;

    // the clear bit lives exactly one cycle after the write
    next_state.capture_store_clear = 1'b0;

    // register writes: only the select bits and the clear bit take data
    if (reg_write) begin
      logic [31:0] merged;
      merged = merge_bytes(control_image(state, store_count), pwdata,
                           pstrb);
      next_state.select = mask_select(merged[SOURCE_LSB +: SOURCE_COUNT]);
      next_state.capture_store_clear = merged[BIT_STORE_CLEAR] &&
                                       pstrb[BIT_STORE_CLEAR/8];
    end

    // bus answer, registered for the access phase
    next_state.pready  = setup_phase;
    next_state.pslverr = setup_phase && !addr_hit;
    if (setup_phase) begin
      next_state.prdata = addr_hit && !pwrite ?
                          control_image(state, store_count) : 32'h00000000;
    end

    // sequencer: decided at a first word, held until its last word
    case (state.seq)
      SEQ_IDLE: begin
        if (packet_in.valid && packet_in.first && !packet_in.last) begin
          next_state.seq = select_hit && store_has_room ? SEQ_TAKE
                                                        : SEQ_SKIP;
        end
      end
      SEQ_TAKE: begin
        if (closes_packet(packet_in)) begin
          next_state.seq = SEQ_IDLE;
        end else if (packet_in.valid && !store_has_room) begin
          next_state.seq = SEQ_SKIP; // truncate on overflow
        end
      end
      SEQ_SKIP: begin
        if (closes_packet(packet_in)) begin
          next_state.seq = SEQ_IDLE;
        end
      end
      default: begin
        next_state.seq = SEQ_IDLE;
      end
    endcase
    // a clear also abandons the packet in progress, or the whole next packet if none is
    if (state.capture_store_clear) begin
      next_state.seq = SEQ_SKIP;
      if (closes_packet(packet_in)) begin
        next_state.seq = SEQ_IDLE;
      end
    end

    // readout register: one-cycle valid per popped quadlet
    next_state.log_out.valid = store_pop;
    if (store_pop) begin
      next_state.log_out.word = store_head;
    end

    // full flag follows the occupancy after this cycle's strobes
    // worked out ahead so the flag and the register image always agree
    next_state.capture_store_full = !state.capture_store_clear &&
      ((store_is_full(store_count) && !store_pop) ||
       (store_count == STORE_DEPTH_COUNT - 7'h01 && store_push &&
        !store_pop));
  end

  // ********************************************************************
  // state register
  // ********************************************************************
  // only presetn (device reset) touches this; no bus reset input exists
  // ce low holds every field, so a stalled bus or packet path loses nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= STATE_RESET;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // ********************************************************************
  // log store
  // ********************************************************************
  capture_store u_store (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .clear     (state.capture_store_clear),
    .push      (store_push),
    .push_word (packet_in.word),
    .pop       (store_pop),
    .head_word (store_head),
    .count     (store_count)
  );

  // ********************************************************************
  // outputs, all straight from the state register
  // ********************************************************************
  assign prdata             = state.prdata;
  assign pready             = state.pready;
  assign pslverr            = state.pslverr;
  assign log_out            = state.log_out;
  assign capture_store_full = state.capture_store_full;

endmodule : packet_log_capture_select

// [hw/capture_log_pkg.sv]
/*
  Shared constants and carrier types for the packet log capture selector:
  register map, control field positions, store geometry and the packet
  and readout carriers.
  Assumes a 32-bit APB register bus and one system clock for all users.
*/
package capture_log_pkg;

  // ********************************************************************
  // register map
  // ********************************************************************
  localparam logic [7:0]  CAPTURE_CONTROL_ADDR  = 8'hF8;
  localparam logic [31:0] CAPTURE_CONTROL_RESET = 32'h00000000;

  // ********************************************************************
  // control register field positions
  // ********************************************************************
  localparam int SOURCE_COUNT      = 12;
  localparam int SOURCE_LSB        = 0;
  localparam int BIT_ASYNC_TX      = 0;
  localparam int BIT_ASYNC_RX      = 1;
  localparam int BIT_MGMT_AGENT    = 2;
  localparam int BIT_MGMT_TX_QUEUE = 3;
  localparam int BIT_MGMT_RX_FIFO  = 4;
  localparam int BIT_CMD_AGENT     = 5;
  localparam int BIT_CMD_TX_QUEUE  = 6;
  localparam int BIT_CMD_RX_FIFO   = 7;
  localparam int BIT_DATA_TX_WRREQ = 8;
  localparam int BIT_DATA_TX_WRRSP = 9;
  localparam int BIT_DATA_RX_RDREQ = 10;
  localparam int BIT_DATA_RX_RDRSP = 11;
  localparam int BIT_STORE_CLEAR   = 15;
  localparam int BIT_STORE_FULL    = 19;
  localparam int SPACE_LSB         = 20;
  localparam int SPACE_WIDTH       = 12;

  // ********************************************************************
  // store geometry
  // ********************************************************************
  localparam int STORE_DEPTH = 64;
  localparam int STORE_AW    = 6;
  localparam int STORE_CW    = 7;
  localparam logic [STORE_CW-1:0] STORE_DEPTH_COUNT = 7'h40;

  // ********************************************************************
  // carriers
  // ********************************************************************
  typedef logic [SOURCE_COUNT-1:0] source_mask_t;

  // one quadlet of a packet seen on the internal packet paths
  typedef struct packed {
    logic         valid;
    logic         first;
    logic         last;
    source_mask_t sources;
    logic [31:0]  word;
  } packet_word_s;

  // one quadlet handed out of the store
  typedef struct packed {
    logic        valid;
    logic [31:0] word;
  } log_word_s;

endpackage : capture_log_pkg

// [hw/capture_store.sv]
/*
  Packet log store: a first-in first-out quadlet memory with a
  synchronous clear and an occupancy count.
  Assumes the caller never pushes when full nor pops when empty; the
  store itself ignores every strobe while the clock enable is low.
*/
module capture_store
  import capture_log_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                ce,
  input  wire logic                clear,
  input  wire logic                push,
  input  wire logic [31:0]         push_word,
  input  wire logic                pop,
  output logic      [31:0]         head_word,
  output logic      [STORE_CW-1:0] count
);

  typedef struct packed {
    logic [STORE_AW-1:0] wr_ptr;
    logic [STORE_AW-1:0] rd_ptr;
    logic [STORE_CW-1:0] count;
  } store_state_s;

  store_state_s        state;
  store_state_s        next_state;
  logic [31:0]         mem [STORE_DEPTH];

  // ********************************************************************
  // pointer and count update
  // ********************************************************************
  // clear outranks push and pop so a clear leaves the store truly empty
  always_comb begin
    next_state = state;
    if (clear) begin
      next_state = '0;
    end else begin
      if (push) begin
        next_state.wr_ptr = state.wr_ptr + STORE_AW'(1);
      end
      if (pop) begin
        next_state.rd_ptr = state.rd_ptr + STORE_AW'(1);
      end
      case ({push, pop})
        2'b10:   next_state.count = state.count + STORE_CW'(1);
        2'b01:   next_state.count = state.count - STORE_CW'(1);
        default: next_state.count = state.count;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '0;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // memory has no reset; only written words are ever read out
  always_ff @(posedge pclk) begin
    if (ce && push && !clear) begin
      mem[state.wr_ptr] <= push_word;
    end
  end

  assign head_word = mem[state.rd_ptr];
  assign count     = state.count;

endmodule : capture_store

// [bench/packet_log_capture_select_properties.sv]
/*
  Checker for the packet log capture selector: port-level relations of
  the register bus, the log store flags and the readout port.
  Assumes one clock, pclk, and asynchronous active-low presetn.
*/
module packet_log_capture_select_checker
  import capture_log_pkg::*;
(
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         ce,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pwrite,
  input wire logic [31:0]  paddr,
  input wire logic [31:0]  pwdata,
  input wire logic [3:0]   pstrb,
  input wire logic [31:0]  prdata,
  input wire logic         pready,
  input wire logic         pslverr,
  input wire packet_word_s packet_in,
  input wire logic         log_read,
  input wire log_word_s    log_out,
  input wire logic         capture_store_full
);
  // ******************************************************************
  // assertions
  // ******************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_reset_quiet: assert property ($rose(presetn) |->
    !pready && !capture_store_full && !log_out.valid)
    else $error("outputs not quiet after reset");
  chk_access_ready: assert property (psel && !penable && ce |=> pready)
    else $error("no ready in access phase");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_unmapped_err: assert property (psel && !penable && ce &&
    paddr != 32'h0000_00F8 |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  chk_clear_empties: assert property (psel && penable && pwrite && ce &&
    paddr == 32'h0000_00F8 && pwdata[15] && pstrb[1]
    |-> ##[1:3] !capture_store_full)
    else $error("clear did not empty store");
  chk_full_bit: assert property (pready && !pwrite && !pslverr &&
    $past(ce) |-> prdata[19] == $past(capture_store_full))
    else $error("full bit differs from full flag");
  chk_full_space: assert property (pready && !pwrite && prdata[19]
    |-> prdata[31:20] == 12'h000)
    else $error("full store shows free space");
  chk_full_cause: assert property ($rose(capture_store_full) |->
    $past(packet_in.valid) || $past(packet_in.valid, 2))
    else $error("store filled without a packet word");
  chk_pop_cause: assert property (log_out.valid |-> $past(log_read))
    else $error("log word without read request");
  chk_free_bits: assert property (pready && !pwrite |->
    prdata[18:16] == 3'h0 && prdata[14:12] == 3'h0)
    else $error("unused control bits read nonzero");

  // main scenarios reached
  cover property (psel && penable && pwrite && pready);
  cover property ($rose(capture_store_full));
  cover property (log_out.valid);
  cover property (pready && pslverr);
endmodule : packet_log_capture_select_checker

bind packet_log_capture_select packet_log_capture_select_checker i_checker (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .packet_in(packet_in), .log_read(log_read), .log_out(log_out),
  .capture_store_full(capture_store_full));

// [bench/packet_log_capture_select_tb_top.sv]
/*
  Self-checking testbench for the packet log capture selector.
  Assumes the design answers every APB setup with pready one cycle
  later and that ce may stay high throughout.
*/
module packet_log_capture_select_tb_top
  import capture_log_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic         pclk;
  logic         presetn;
  logic         ce;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [31:0]  paddr;
  logic [31:0]  pwdata;
  logic [3:0]   pstrb;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  packet_word_s packet_in;
  logic         log_read;
  log_word_s    log_out;
  logic         capture_store_full;
  int           bad_count;
  int           check_count;
  logic [31:0]  exp_q[$];

  packet_log_capture_select i_packet_log_capture_select (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .packet_in(packet_in), .log_read(log_read), .log_out(log_out),
    .capture_store_full(capture_store_full));

  // ******************************************************************
  // helpers
  // ******************************************************************
  always #5 pclk = ~pclk;

  task automatic check(input string nm, input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // expected control image: free space, full, selects
  function automatic logic [31:0] img(logic [11:0] sel, int used,
                                      logic full);
    return {12'(64 - used), full, 7'h00, sel};
  endfunction : img

  // answer taken at the edge that samples pready high, then released
  task automatic apb(input logic wr, input logic [31:0] a, d,
                     input logic [3:0] s, output logic [31:0] rd,
                     output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr;
    paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // pready is read at the edge, before that edge updates it
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (pready !== 1'b1) begin
      bad_count++;
      $display("CHECK FAILED apb_wait expected ready seen none");
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [31:0] d, input logic [3:0] s);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, 32'h0000_00F8, d, s, rd, er);
  endtask : wr

  task automatic reg_chk(input string nm, input logic [31:0] exp);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, 32'h0000_00F8, 32'h0000_0000, 4'h0, rd, er);
    check(nm, rd, exp);
  endtask : reg_chk

  // back-to-back quadlets of one packet
  task automatic pkt(input logic [11:0] src, input int n,
                     input logic [31:0] base, input bit keep);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      packet_in <= '{valid: 1'b1, first: i == 0, last: i == n - 1,
                     sources: src, word: base + i};
      if (keep) exp_q.push_back(base + i);
    end
    @(posedge pclk);
    packet_in <= '0;
  endtask : pkt

  task automatic drain();
    logic [31:0] e;
    while (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      @(posedge pclk);
      log_read <= 1'b1;
      @(posedge pclk);
      log_read <= 1'b0;
      #1;
      check("log_valid", log_out.valid, 1);
      check("log_word", log_out.word, e);
    end
  endtask : drain

  // ******************************************************************
  // scenarios
  // ******************************************************************
  task automatic t_regs();
    reg_chk("reset_image", img(12'h000, 0, 1'b0));
    wr(32'h0000_0FFF, 4'hF);
    reg_chk("all_selects", img(12'hFFF, 0, 1'b0));
    wr(32'h0000_0000, 4'h1); // only byte 0 may change
    reg_chk("lane_write", img(12'hF00, 0, 1'b0));
  endtask : t_regs

  // each select alone: its source kept, every other source dropped
  task automatic t_select();
    logic [11:0] m;
    for (int n = 0; n < 12; n++) begin
      m = 12'h001 << n;
      wr({20'h00000, m}, 4'hF);
      pkt(m, 1, 32'h0000_1000 + n, 1'b1);
      pkt(~m, 2, 32'h0000_2000, 1'b0);
      reg_chk("one_select", img(m, 1, 1'b0));
      drain();
    end
  endtask : t_select

  task automatic t_order();
    wr(32'h0000_00A5, 4'hF);
    pkt(12'h304, 3, 32'h0000_3100, 1'b1);
    pkt(12'h00A, 2, 32'h0000_3200, 1'b0);
    pkt(12'h080, 4, 32'h0000_3300, 1'b1);
    pkt(12'h000, 1, 32'h0000_3400, 1'b0);
    ce <= 1'b0; // frozen block must not take this selected packet
    pkt(12'h0A5, 2, 32'h0000_3500, 1'b0);
    ce <= 1'b1;
    reg_chk("mixed_image", img(12'h0A5, 7, 1'b0));
    drain();
  endtask : t_order

  task automatic t_full();
    wr(32'h0000_0FFF, 4'hF);
    for (int p = 0; p < 16; p++) pkt(12'h001, 4, 32'h0000_4000 + 4 * p, 1);
    pkt(12'hFFF, 1, 32'h0000_5000, 1'b0);
    repeat (2) @(posedge pclk);
    #1;
    check("full_flag", capture_store_full, 1);
    reg_chk("full_image", img(12'hFFF, 64, 1'b1));
    wr(32'h0000_8FFF, 4'hF);
    repeat (2) @(posedge pclk);
    #1;
    check("cleared_flag", capture_store_full, 0);
    reg_chk("cleared_image", img(12'hFFF, 0, 1'b0));
    exp_q.delete();
    @(posedge pclk);
    log_read <= 1'b1;
    @(posedge pclk);
    log_read <= 1'b0;
    #1;
    check("empty_pop", log_out.valid, 0);
  endtask : t_full

  task automatic t_unmapped();
    logic [31:0] rd;
    logic        er;
    apb(1'b1, 32'h0000_00F4, 32'h0000_0000, 4'hF, rd, er);
    check("bad_write_err", er, 1);
    apb(1'b0, 32'h0000_00F4, 32'h0000_0000, 4'h0, rd, er);
    check("bad_read_err", er, 1);
    check("bad_read_data", rd, 32'h0000_0000);
    reg_chk("kept_image", img(12'hFFF, 0, 1'b0));
  endtask : t_unmapped

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results

  // ******************************************************************
  // main sequence and watchdog
  // ******************************************************************
  initial begin
    pclk = 1'b0; presetn = 1'b0; ce = 1'b1; psel = 1'b0;
    penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    pstrb = '0; packet_in = '0; log_read = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_select();
    t_order();
    t_full();
    t_unmapped();
    results();
  end

  // run needs a few hundred cycles; far longer means a hang
  initial begin
    #200000;
    bad_count++;
    results();
  end
endmodule : packet_log_capture_select_tb_top
